// >>> hw/adcsel_map.vh
// addresses, field positions, reset values and decode constants of the adc select block
`ifndef ADCSEL_MAP_VH
`define ADCSEL_MAP_VH

// register addresses on the sfr port
`define ADCSEL_ADDR_CFG        8'hbc
`define ADCSEL_ADDR_CHAN       8'hbb
`define ADCSEL_ADDR_PAIR       8'hba

// reset values
`define ADCSEL_RST_CFG         8'hf8
`define ADCSEL_RST_CHAN        4'h0
`define ADCSEL_RST_PAIR        4'h0
`define ADCSEL_ZERO_BYTE       8'h00

// field positions
`define ADCSEL_DIV_HI          7
`define ADCSEL_DIV_LO          3
`define ADCSEL_GAIN_HI         2
`define ADCSEL_GAIN_LO         0
`define ADCSEL_CODE_HI         3
`define ADCSEL_CODE_LO         0
`define ADCSEL_TEMP_BIT        3
`define ADCSEL_PAIR_HI         3
`define ADCSEL_PAIR_LO         0

// divider constants
`define ADCSEL_DIV_ZERO        5'h00
`define ADCSEL_DIV_ONE         5'h01

// gain codes and gain expressed in half steps (gain * 2)
`define ADCSEL_GAIN_1          3'h0
`define ADCSEL_GAIN_2          3'h1
`define ADCSEL_GAIN_4          3'h2
`define ADCSEL_GAIN_8          3'h3
`define ADCSEL_GAIN_16A        3'h4
`define ADCSEL_GAIN_16B        3'h5
`define ADCSEL_HALF_1          6'h02
`define ADCSEL_HALF_2          6'h04
`define ADCSEL_HALF_4          6'h08
`define ADCSEL_HALF_8          6'h10
`define ADCSEL_HALF_16         6'h20
`define ADCSEL_HALF_05         6'h01

// rate limit: system clock and sar ceiling in khz
`define ADCSEL_SYSTEM_CLOCK_KHZ      100000
`define ADCSEL_SAR_MAX_KHZ     2500
`define ADCSEL_PERIOD_HALVES   2

`endif

// >>> hw/adcsel_clkdiv.v
// sar conversion clock divider: tick once per sar period plus a square wave for nonzero n; at n = 0 the level is held high
`timescale 1ns/1ps
module adcsel_clkdiv
(
	input  wire       mclk,
	input  wire       arst_n,
	input  wire [4:0] div_n,
	output reg        sar_tick,
	output reg        sar_level
);
`include "adcsel_map.vh"

	reg  [4:0] half_cnt;
	reg  [4:0] last_n;
	reg  [4:0] next_half_cnt;
	reg        next_tick;
	reg        next_level;
	wire       n_changed;

	// restart on any divider change so a new period never runs from a stale count
	assign n_changed = (div_n != last_n);

	always @*
	begin
		next_half_cnt = half_cnt;
		next_tick     = 1'b0;
		next_level    = sar_level;
		if (div_n == `ADCSEL_DIV_ZERO)
		begin
			// full rate: a tick every cycle, level held high
			next_half_cnt = `ADCSEL_DIV_ZERO;
			next_tick     = 1'b1;
			next_level    = 1'b1;
		end
		else if (n_changed)
		begin
			next_half_cnt = `ADCSEL_DIV_ZERO;
			next_level    = 1'b0;
		end
		else if (half_cnt == div_n)
		begin
			// each half period lasts n + 1 cycles
			next_half_cnt = `ADCSEL_DIV_ZERO;
			next_level    = ~sar_level;
			next_tick     = ~sar_level;
		end
		else
		begin
			next_half_cnt = half_cnt + `ADCSEL_DIV_ONE;
		end
	end

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			half_cnt  <= 5'h00;
			last_n    <= 5'h00;
			sar_tick  <= 1'b0;
			sar_level <= 1'b0;
		end
		else
		begin
			half_cnt  <= next_half_cnt;
			last_n    <= div_n;
			sar_tick  <= next_tick;
			sar_level <= next_level;
		end
	end

endmodule // adcsel_clkdiv

// >>> hw/adcsel_top.v
// adc input select, pair configuration, sar clock and gain configuration registers
`timescale 1ns/1ps
module adcsel_top
(
	input  wire       mclk,
	input  wire       arst_n,
	input  wire [7:0] sfr_addr,
	input  wire       sfr_wr,
	input  wire [7:0] sfr_wdata,
	input  wire       sfr_rd,
	output reg  [7:0] sfr_rdata,
	output wire       sar_clk_tick,
	output wire       sar_clk_level,
	output reg        sar_rate_over_limit,
	output reg  [7:0] mux_pos_sel,
	output reg  [7:0] mux_neg_sel,
	output reg        mux_differential,
	output reg        temp_sensor_sel,
	output reg  [2:0] amplifier_gain_field,
	output reg  [5:0] gain_half_steps
);
`include "adcsel_map.vh"

	////////////////////////////////////////////////////////////////////////////////
	// sfr registers

	reg  [7:0] adc_clock_and_gain_config;
	reg  [3:0] channel_code_field;
	reg  [3:0] input_pair_config;

	wire       wr_cfg;
	wire       wr_chan;
	wire       wr_pair;
	wire [4:0] sar_clock_divider_field;
	wire [2:0] gain_field;

	assign wr_cfg  = sfr_wr && (sfr_addr == `ADCSEL_ADDR_CFG);
	assign wr_chan = sfr_wr && (sfr_addr == `ADCSEL_ADDR_CHAN);
	assign wr_pair = sfr_wr && (sfr_addr == `ADCSEL_ADDR_PAIR);

	assign sar_clock_divider_field = adc_clock_and_gain_config[`ADCSEL_DIV_HI:`ADCSEL_DIV_LO];
	assign gain_field              = adc_clock_and_gain_config[`ADCSEL_GAIN_HI:`ADCSEL_GAIN_LO];

	// writes land at the edge that samples the strobe; no wait states
	// upper nibbles of the select and pair registers are not stored and read zero
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			adc_clock_and_gain_config <= `ADCSEL_RST_CFG;
			channel_code_field        <= `ADCSEL_RST_CHAN;
			input_pair_config         <= `ADCSEL_RST_PAIR;
		end
		else
		begin
			if (wr_cfg)
				adc_clock_and_gain_config <= sfr_wdata;
			if (wr_chan)
				channel_code_field <= sfr_wdata[`ADCSEL_CODE_HI:`ADCSEL_CODE_LO];
			if (wr_pair)
				input_pair_config <= sfr_wdata[`ADCSEL_PAIR_HI:`ADCSEL_PAIR_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path, one cycle after the read strobe

	reg  [7:0] next_rdata;

	// unmapped addresses read zero and swallow writes
	always @*
	begin
		next_rdata = `ADCSEL_ZERO_BYTE;
		case (sfr_addr)
			`ADCSEL_ADDR_CFG:
				next_rdata = adc_clock_and_gain_config;
			`ADCSEL_ADDR_CHAN:
				next_rdata = {4'h0, channel_code_field};
			`ADCSEL_ADDR_PAIR:
				next_rdata = {4'h0, input_pair_config};
			default:
				next_rdata = `ADCSEL_ZERO_BYTE;
		endcase
	end

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sfr_rdata <= `ADCSEL_ZERO_BYTE;
		else if (sfr_rd)
			sfr_rdata <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////////////////
	// sar conversion clock

	adcsel_clkdiv u_clkdiv
	(
		.mclk      (mclk),
		.arst_n    (arst_n),
		.div_n     (sar_clock_divider_field),
		.sar_tick  (sar_clk_tick),
		.sar_level (sar_clk_level)
	);

	// flag divider settings that push the sar clock above its ceiling;
	// the block still obeys such a setting, software owns the choice
	// smallest n + 1 that keeps the sar clock under its ceiling;
	// rounded up so a ceiling that does not divide evenly stays on the safe side
	localparam integer MIN_DIV_INT =
		`ADCSEL_SYSTEM_CLOCK_KHZ / (`ADCSEL_PERIOD_HALVES * `ADCSEL_SAR_MAX_KHZ) +
		((`ADCSEL_SYSTEM_CLOCK_KHZ % (`ADCSEL_PERIOD_HALVES * `ADCSEL_SAR_MAX_KHZ)) != 0);
	localparam [5:0] MIN_DIVISOR = MIN_DIV_INT[5:0];

	wire [5:0] divisor_plus;
	wire       next_over_limit;

	assign divisor_plus    = {1'b0, sar_clock_divider_field} + 6'h01;
	assign next_over_limit = (sar_clock_divider_field == `ADCSEL_DIV_ZERO) ||
				 (divisor_plus < MIN_DIVISOR);

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sar_rate_over_limit <= 1'b0;
		else
			sar_rate_over_limit <= next_over_limit;
	end

	////////////////////////////////////////////////////////////////////////////////
	// amplifier gain decode

	reg  [5:0] next_gain;

	// 11x attenuates by half, so gain is carried in half steps

	always @*
	begin
		next_gain = `ADCSEL_HALF_1;
		case (gain_field)
			`ADCSEL_GAIN_1:
				next_gain = `ADCSEL_HALF_1;
			`ADCSEL_GAIN_2:
				next_gain = `ADCSEL_HALF_2;
			`ADCSEL_GAIN_4:
				next_gain = `ADCSEL_HALF_4;
			`ADCSEL_GAIN_8:
				next_gain = `ADCSEL_HALF_8;
			`ADCSEL_GAIN_16A,
			`ADCSEL_GAIN_16B:
				next_gain = `ADCSEL_HALF_16;
			default:
				next_gain = `ADCSEL_HALF_05;
		endcase
	end

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			amplifier_gain_field <= 3'h0;
			gain_half_steps      <= 6'h00;
		end
		else
		begin
			amplifier_gain_field <= gain_field;
			gain_half_steps      <= next_gain;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// channel decode

	wire       code_temp;
	wire [2:0] code_chan;
	wire [1:0] code_pair;
	wire       pair_diff;
	wire [7:0] next_pos;
	wire [7:0] next_neg;

	// temp code wins over the pair bit so a sensor read never drives the neg side
	assign code_temp = channel_code_field[`ADCSEL_TEMP_BIT];
	assign code_chan = channel_code_field[2:0];
	assign code_pair = code_chan[2:1];
	assign pair_diff = input_pair_config[code_pair] && !code_temp;

	// odd code of a differential pair routes the same pair, never a lone half
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_input
			if (gi % 2 == 0)
			begin : g_even
				assign next_pos[gi] = !code_temp &&
					(pair_diff ? (code_pair == gi / 2) : (code_chan == gi));
				assign next_neg[gi] = 1'b0;
			end
			else
			begin : g_odd
				assign next_pos[gi] = !code_temp && !pair_diff && (code_chan == gi);
				assign next_neg[gi] = pair_diff && (code_pair == gi / 2);
			end
		end
	endgenerate

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mux_pos_sel      <= 8'h00;
			mux_neg_sel      <= 8'h00;
			mux_differential <= 1'b0;
			temp_sensor_sel  <= 1'b0;
		end
		else
		begin
			mux_pos_sel      <= next_pos;
			mux_neg_sel      <= next_neg;
			mux_differential <= pair_diff;
			temp_sensor_sel  <= code_temp;
		end
	end

endmodule // adcsel_top

// >>> tb/adcsel_props.sv
// concurrent checks on the adc select block ports
`timescale 1ns/1ps
module adcsel_props
(
	input wire       mclk,
	input wire       arst_n,
	input wire [7:0] sfr_addr,
	input wire       sfr_wr,
	input wire [7:0] sfr_wdata,
	input wire       sfr_rd,
	input wire [7:0] sfr_rdata,
	input wire       sar_clk_tick,
	input wire       sar_clk_level,
	input wire [7:0] mux_pos_sel,
	input wire [7:0] mux_neg_sel,
	input wire       mux_differential,
	input wire       temp_sensor_sel,
	input wire [2:0] amplifier_gain_field,
	input wire [5:0] gain_half_steps
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_wcfg; sfr_wr && sfr_addr == 8'hbc; endsequence
	sequence s_rcfg; sfr_rd && sfr_addr == 8'hbc; endsequence
	a_cfg_readback: assert property (s_wcfg ##1 s_rcfg |=> sfr_rdata == $past(sfr_wdata, 2))
		else $error("cfg readback wrong");
	a_gain_copy: assert property (s_wcfg |-> ##2 amplifier_gain_field == $past(sfr_wdata[2:0], 2))
		else $error("gain field not copied");
	// past reset guard: outputs still hold zeros at the release edge
	a_gain_decode: assert property ($past(arst_n) |-> gain_half_steps ==
		(amplifier_gain_field == 3'h0 ? 6'h02 : amplifier_gain_field == 3'h1 ? 6'h04 :
		amplifier_gain_field == 3'h2 ? 6'h08 : amplifier_gain_field == 3'h3 ? 6'h10 :
		amplifier_gain_field[1] ? 6'h01 : 6'h20))
		else $error("gain decode wrong");
	a_temp_route: assert property (sfr_wr && sfr_addr == 8'hbb && sfr_wdata[3]
		|-> ##2 temp_sensor_sel && mux_pos_sel == 8'h00) else $error("temp not routed");
	a_diff_pair: assert property (mux_differential |-> mux_neg_sel == {mux_pos_sel[6:0], 1'b0})
		else $error("pair neg not odd");
	a_single_neg: assert property (!mux_differential |-> mux_neg_sel == 8'h00)
		else $error("neg set in single mode");
	a_unmapped_rd: assert property (sfr_rd && sfr_addr == 8'hbe |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_tick_rise: assert property ($rose(sar_clk_level) |-> sar_clk_tick)
		else $error("tick missing at rise");
	a_full_rate: assert property (sfr_wr && sfr_addr == 8'hbc && sfr_wdata[7:3] == 5'h00
		|-> ##2 sar_clk_tick && sar_clk_level) else $error("full rate sar clock missing");
endmodule // adcsel_props

// >>> tb/adcsel_top_bench.sv
// register level bench for the adc select block
`timescale 1ns/1ps
module adcsel_top_bench;
	reg        mclk;
	reg        arst_n;
	reg  [7:0] sfr_addr;
	reg        sfr_wr;
	reg  [7:0] sfr_wdata;
	reg        sfr_rd;
	wire [7:0] sfr_rdata;
	wire       sar_clk_tick;
	wire       sar_clk_level;
	wire       sar_rate_over_limit;
	wire [7:0] mux_pos_sel;
	wire [7:0] mux_neg_sel;
	wire       mux_differential;
	wire       temp_sensor_sel;
	wire [2:0] amplifier_gain_field;
	wire [5:0] gain_half_steps;
	reg  [5:0] gt [0:7];
	reg  [4:0] nt [0:4];
	reg  [7:0] ep;
	reg  [7:0] en;
	reg        ed;
	reg  [3:0] c;
	reg  [3:0] p;
	integer    bad_count;
	integer    n_checks;
	integer    cyc;
	integer    i;
	integer    k;
	adcsel_top dut (.*);
	////////////////////////////////////////////////////////////////////////////////
	task end_of_test;
	begin
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	task chk(input [63:0] nm, input [7:0] e, input [7:0] s);
	begin
		n_checks = n_checks + 1;
		if (s !== e)
		begin
			bad_count = bad_count + 1;
			$display("BAD %0s exp %h got %h", nm, e, s);
		end
	end
	endtask
	// strobes stay up between back to back accesses; idle drops them
	task wr(input [7:0] a, input [7:0] d);
	begin
		sfr_addr = a;
		sfr_wdata = d;
		sfr_rd = 1'b0;
		sfr_wr = 1'b1;
		@(posedge mclk);
		#1;
	end
	endtask
	task rd(input [7:0] a, input [7:0] e);
	begin
		sfr_addr = a;
		sfr_wr = 1'b0;
		sfr_rd = 1'b1;
		@(posedge mclk);
		#1;
		chk("rdata", e, sfr_rdata);
	end
	endtask
	task idle;
	begin
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
	end
	endtask
	// skip ticks of the old rate before measuring: a change restarts the count
	task per(input [4:0] n);
	begin
		wr(8'hbc, {n, 3'h0});
		idle;
		repeat (4) @(posedge mclk);
		#1;
		k = 0;
		while (sar_clk_tick !== 1'b1 && k < 200)
		begin
			@(posedge mclk);
			#1;
			k = k + 1;
		end
		k = 0;
		do
		begin
			@(posedge mclk);
			#1;
			k = k + 1;
		end
		while (sar_clk_tick !== 1'b1 && k < 200);
		chk("period", (n == 5'h00) ? 8'h01 : {1'b0, n + 6'h01, 1'b0}, k[7:0]);
		chk("lvl", 8'h01, {7'h0, sar_clk_level});
		// 100 mhz over 2 * 2.5 mhz: n below 19 runs the sar clock too fast
		chk("ovl", {7'h0, n < 5'h13}, {7'h0, sar_rate_over_limit});
	end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			bad_count = bad_count + 1;
			end_of_test;
		end
	end
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		arst_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_wdata = 8'h00;
		sfr_rd = 1'b0;
		bad_count = 0;
		n_checks = 0;
		cyc = 0;
		gt = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h20, 6'h01, 6'h01};
		nt = '{5'h00, 5'h01, 5'h04, 5'h13, 5'h1f};
		repeat (5) @(posedge mclk);
		#1;
		arst_n = 1'b1;
		rd(8'hbc, 8'hf8);
		rd(8'hbb, 8'h00);
		rd(8'hba, 8'h00);
		wr(8'hbe, 8'hff);
		rd(8'hbe, 8'h00);
		rd(8'hbc, 8'hf8);
		chk("gain", 8'h02, {2'h0, gain_half_steps});
		for (i = 0; i < 8; i = i + 1)
		begin
			wr(8'hbc, {5'h13, i[2:0]});
			rd(8'hbc, {5'h13, i[2:0]});
			chk("gain", {2'h0, gt[i]}, {2'h0, gain_half_steps});
		end
		for (k = 0; k < 4; k = k + 1)
		begin
			p = {2'h0, k[1:0]} * 4'h5;
			wr(8'hba, {4'hf, p});
			rd(8'hba, {4'h0, p});
			for (i = 0; i < 16; i = i + 1)
			begin
				c = i[3:0];
				wr(8'hbb, {4'ha, c});
				rd(8'hbb, {4'h0, c});
				ed = !c[3] && p[c[2:1]];
				ep = c[3] ? 8'h00 : 8'h01 << (ed ? {c[2:1], 1'b0} : c[2:0]);
				en = ed ? {ep[6:0], 1'b0} : 8'h00;
				chk("pos", ep, mux_pos_sel);
				chk("neg", en, mux_neg_sel);
				chk("dif", {7'h0, ed}, {7'h0, mux_differential});
				chk("tmp", {7'h0, c[3]}, {7'h0, temp_sensor_sel});
			end
		end
		// mid-run reset: registers and routing fall back to reset values
		wr(8'hba, 8'h0f);
		wr(8'hbb, 8'h02);
		idle;
		arst_n = 1'b0;
		@(posedge mclk);
		#1;
		chk("rstrd", 8'h00, sfr_rdata);
		chk("rstpos", 8'h00, mux_pos_sel);
		arst_n = 1'b1;
		rd(8'hbc, 8'hf8);
		rd(8'hbb, 8'h00);
		rd(8'hba, 8'h00);
		chk("pos", 8'h01, mux_pos_sel);
		chk("neg", 8'h00, mux_neg_sel);
		chk("dif", 8'h00, {7'h0, mux_differential});
		chk("gain", 8'h02, {2'h0, gain_half_steps});
		chk("ovl", 8'h00, {7'h0, sar_rate_over_limit});
		for (i = 0; i < 5; i = i + 1)
			per(nt[i]);
		end_of_test;
	end
endmodule // adcsel_top_bench
bind adcsel_top adcsel_props u_props (.*);
